//--- hdl/torque_off_test_stop_interlock.sv
`timescale 1ns/1ns
`include "torque_off_map.svh"

module torque_off_test_stop_interlock
  import torque_off_pkg::*;
#(
  parameter int TICK_CYCLES = `MS_CYCLES,
  parameter int CHECK_MS = `CHECK_TIME_MS,
  parameter int DISC_MS = `DISC_TIME_MS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Safety inputs and drive commands
  input wire safety_in_t safety_in,
  input wire drive_cmd_t drive_cmd,
  // Drive state
  output logic torque_off_active_main,
  output logic torque_off_active_extended,
  output logic terminal_select_cause_flag,
  output logic motor_enable,
  output logic safety_output,
  output logic main_test_request_flag,
  output logic extended_test_request_flag,
  // Alarms and interrupt
  output alarm_out_t alarms,
  output logic irq
);

  localparam int NT = 4;
  localparam int T_MAIN = 0;
  localparam int T_TERM = 1;
  localparam int T_EXT = 2;
  localparam int T_OUT = 3;
  localparam int NEV = 6;

  typedef struct packed {
    test_state_t fsm;
    logic is_term;
    logic [19:0] tick_cnt;
    logic [7:0] ms_cnt;
    logic [7:0] disc_cnt;
    logic [NT-1:0][23:0] due_cnt;
    logic [NT-1:0][23:0] interval;
    logic [NT-1:0] due;
    logic [2:0] mode;
    logic [NEV-1:0] irq_stat;
    logic [NEV-1:0] irq_mask;
    logic motor_on;
    logic run_d;
    logic ext_d;
    logic out_d;
    logic sto_d;
    logic disc_fault;
    logic start_fault;
    logic out_level;
    logic [31:0] rdata;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic tick;
  logic sel;
  logic safe_torque_off;
  logic ready_for_test;
  logic [NT-1:0] restart;
  logic [NEV-1:0] events;
  logic [31:0] status_word;
  logic run_rise;
  logic ext_rise;
  logic out_rise;
  logic sto_rise;
  logic chan_differ;

  assign tick = (state_reg.tick_cnt == 20'(TICK_CYCLES - 1));
  // A low on either channel selects torque-off, so a broken wire fails safe.
  assign sel = !safety_in.sel_ch_a_n || !safety_in.sel_ch_b_n;
  assign safe_torque_off = sel || safety_in.terminal_select || state_reg.disc_fault;
  // Main and extended tests are only accepted from a switched-on motor at standstill.
  assign ready_for_test = state_reg.motor_on && safety_in.speed_zero;

  // Edges are taken against the level of the previous cycle, so a held level acts once.
  assign run_rise = drive_cmd.run_command && !state_reg.run_d;
  assign ext_rise = safety_in.ext_start && !state_reg.ext_d;
  assign out_rise = safety_in.out_start && !state_reg.out_d;
  assign sto_rise = safe_torque_off && !state_reg.sto_d;
  assign chan_differ = (safety_in.sel_ch_a_n != safety_in.sel_ch_b_n);

  assign status_word = {20'h00000,
                        state_reg.fsm,
                        state_reg.out_level,
                        state_reg.motor_on,
                        state_reg.start_fault,
                        state_reg.disc_fault,
                        safe_torque_off,
                        state_reg.due};

  always_comb begin
    state_next = state_reg;
    restart = '0;
    events = '0;

    state_next.tick_cnt = tick ? 20'h00000 : state_reg.tick_cnt + 20'h00001;
    state_next.run_d = drive_cmd.run_command;
    state_next.ext_d = safety_in.ext_start;
    state_next.out_d = safety_in.out_start;
    state_next.sto_d = safe_torque_off;

    // Discrepancy between the two select channels, timed in milliseconds.
    // The fault stays latched after the channels agree until software acknowledges it.
    if (chan_differ) begin
      if (tick && state_reg.disc_cnt != 8'(DISC_MS)) begin
        state_next.disc_cnt = state_reg.disc_cnt + 8'h01;
      end
      if (state_reg.disc_cnt == 8'(DISC_MS) && !state_reg.disc_fault) begin
        state_next.disc_fault = 1'b1;
        events[4] = 1'b1;
      end
    end else begin
      state_next.disc_cnt = 8'h00;
    end

    // Motor switch-on interlock.
    if (safe_torque_off) begin
      state_next.motor_on = 1'b0;
    end else if (!drive_cmd.run_command || !drive_cmd.coast_stop_command_n ||
                 !drive_cmd.quick_stop_command_n) begin
      state_next.motor_on = 1'b0;
    end else if (run_rise) begin
      // The edge is consumed here only when torque-off is inactive.
      state_next.motor_on = 1'b1;
    end

    // Extended start while torque-off is active is refused as a fault.
    if (ext_rise && safe_torque_off && !state_reg.start_fault) begin
      state_next.start_fault = 1'b1;
      events[5] = 1'b1;
    end

    state_next.out_level = 1'b1;

    case (state_reg.fsm)
      ST_IDLE: begin
        state_next.ms_cnt = 8'h00;
        if (sto_rise && ready_for_test && !state_reg.disc_fault) begin
          state_next.is_term = safety_in.terminal_select && !sel;
          state_next.fsm = ST_MAIN_CHECK;
        end else if (ext_rise && !safe_torque_off && ready_for_test) begin
          state_next.fsm = ST_EXT_CHECK;
        end else if (out_rise) begin
          state_next.fsm = ST_OUT_CHECK;
        end
      end
      ST_MAIN_CHECK: begin
        if (tick) begin
          state_next.ms_cnt = state_reg.ms_cnt + 8'h01;
        end
        if (state_reg.ms_cnt == 8'(CHECK_MS)) begin
          state_next.fsm = ST_MAIN_WAIT;
        end
      end
      ST_MAIN_WAIT: begin
        if (!sel && !safety_in.terminal_select) begin
          if (state_reg.is_term) begin
            restart[T_TERM] = 1'b1;
          end else begin
            restart[T_MAIN] = 1'b1;
          end
          state_next.fsm = ST_IDLE;
        end
      end
      ST_EXT_CHECK: begin
        // Torque-off during the check aborts it, and the start is reported as a fault.
        if (safe_torque_off) begin
          state_next.start_fault = 1'b1;
          events[5] = 1'b1;
          state_next.fsm = ST_IDLE;
        end else begin
          if (tick) begin
            state_next.ms_cnt = state_reg.ms_cnt + 8'h01;
          end
          if (state_reg.ms_cnt == 8'(CHECK_MS)) begin
            state_next.fsm = ST_EXT_WAIT;
          end
        end
      end
      ST_EXT_WAIT: begin
        // The controller is expected to drop the start signal here.
        if (!safety_in.ext_start) begin
          restart[T_EXT] = 1'b1;
          restart[T_MAIN] = 1'b1;
          state_next.fsm = ST_IDLE;
        end
      end
      ST_OUT_CHECK: begin
        if (tick) begin
          state_next.ms_cnt = state_reg.ms_cnt + 8'h01;
        end
        // Mode 2 holds off for the whole test, mode 3 for its first half,
        // mode 4 gives two off pulses with an on gap between them.
        case (state_reg.mode)
          3'h3: begin
            state_next.out_level = (state_reg.ms_cnt >= 8'(CHECK_MS / 2));
          end
          3'h4: begin
            state_next.out_level = state_reg.ms_cnt[0];
          end
          default: begin
            state_next.out_level = 1'b0;
          end
        endcase
        if (state_reg.ms_cnt == 8'(CHECK_MS)) begin
          state_next.out_level = 1'b1;
          state_next.fsm = ST_OUT_WAIT;
        end
      end
      ST_OUT_WAIT: begin
        if (!safety_in.out_start) begin
          restart[T_OUT] = 1'b1;
          state_next.fsm = ST_IDLE;
        end
      end
      default: begin
        state_next.fsm = ST_IDLE;
      end
    endcase

    // Interval supervision: counters run in milliseconds toward the limit.
    for (int i = 0; i < NT; i++) begin
      if (restart[i]) begin
        state_next.due_cnt[i] = 24'h000000;
        state_next.due[i] = 1'b0;
      end else begin
        if (tick && state_reg.due_cnt[i] < state_reg.interval[i]) begin
          state_next.due_cnt[i] = state_reg.due_cnt[i] + 24'h000001;
        end
        if (state_reg.due_cnt[i] >= state_reg.interval[i] && !state_reg.due[i]) begin
          state_next.due[i] = 1'b1;
          events[i] = 1'b1;
        end
      end
    end

    // Register writes.
    state_next.rdata = 32'h00000000;
    if (wr) begin
      case (addr)
        `OFS_CTRL: begin
          state_next.mode = wdata[`CTRL_MODE_LSB +: 3];
          if (wdata[`CTRL_ACK_BIT] && !state_next.disc_cnt[0] && !chan_differ) begin
            // Faults clear only once both channels agree again.
            state_next.disc_fault = 1'b0;
            state_next.start_fault = 1'b0;
          end
        end
        `OFS_IRQ_STAT: begin
          state_next.irq_stat = state_reg.irq_stat & ~wdata[NEV-1:0];
        end
        `OFS_IRQ_MASK: begin
          state_next.irq_mask = wdata[NEV-1:0];
        end
        default: begin
          for (int i = 0; i < NT; i++) begin
            if (addr == `OFS_INTERVAL0 + 8'(4 * i)) begin
              state_next.interval[i] = wdata[23:0];
            end
          end
        end
      endcase
    end
    // A new event wins over a simultaneous clear.
    state_next.irq_stat = state_next.irq_stat | events;

    // Register reads; the answer stands in the next cycle only.
    if (rd) begin
      case (addr)
        `OFS_CTRL: begin
          state_next.rdata = {29'h00000000, state_reg.mode};
        end
        `OFS_STATUS: begin
          state_next.rdata = status_word;
        end
        `OFS_IRQ_STAT: begin
          state_next.rdata = {26'h0000000, state_reg.irq_stat};
        end
        `OFS_IRQ_MASK: begin
          state_next.rdata = {26'h0000000, state_reg.irq_mask};
        end
        default: begin
          for (int i = 0; i < NT; i++) begin
            if (addr == `OFS_INTERVAL0 + 8'(4 * i)) begin
              state_next.rdata = {8'h00, state_reg.interval[i]};
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.fsm <= ST_IDLE;
      state_reg.mode <= `CTRL_RESET_MODE;
      state_reg.interval <= {NT{`DEF_INTERVAL_MS}};
      state_reg.out_level <= 1'b1;
      state_reg.sto_d <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdata = state_reg.rdata;
  // Both flags come from one torque-off decision, so they can never disagree.
  assign torque_off_active_main = safe_torque_off;
  assign torque_off_active_extended = safe_torque_off;
  assign terminal_select_cause_flag = safety_in.terminal_select;
  // During an extended check the drive is held at zero torque.
  assign motor_enable = state_reg.motor_on && !safe_torque_off &&
                        state_reg.fsm != ST_EXT_CHECK;
  assign safety_output = state_reg.out_level;
  assign main_test_request_flag = state_reg.due[T_MAIN];
  assign extended_test_request_flag = state_reg.due[T_EXT];

  assign alarms.main_test_due_alarm = state_reg.due[T_MAIN];
  assign alarms.terminal_test_due_alarm = state_reg.due[T_TERM];
  assign alarms.extended_test_due_alarm = state_reg.due[T_EXT];
  assign alarms.output_test_due_alarm = state_reg.due[T_OUT];
  assign alarms.check_running_note_a = (state_reg.fsm == ST_EXT_CHECK);
  assign alarms.check_running_note_b = (state_reg.fsm == ST_EXT_CHECK);
  assign alarms.discrepancy_fault = state_reg.disc_fault;
  assign alarms.test_start_fault = state_reg.start_fault;

  assign irq = |(state_reg.irq_stat & state_reg.irq_mask);

endmodule : torque_off_test_stop_interlock

//--- hdl/torque_off_map.svh
`ifndef TORQUE_OFF_MAP_SVH
`define TORQUE_OFF_MAP_SVH

`define CLK_PERIOD_NS 10
`define MS_IN_NS 1000000
`define MS_CYCLES (`MS_IN_NS / `CLK_PERIOD_NS)
`define CHECK_TIME_MS 4
`define DISC_TIME_MS 10
`define DEF_INTERVAL_MS 24'h7FFFFF

`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_IRQ_STAT 8'h08
`define OFS_IRQ_MASK 8'h0C
`define OFS_INTERVAL0 8'h10

`define CTRL_MODE_LSB 0
`define CTRL_ACK_BIT 8
`define CTRL_RESET_MODE 3'h2

`endif

//--- hdl/torque_off_pkg.sv
package torque_off_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_MAIN_CHECK,
    ST_MAIN_WAIT,
    ST_EXT_CHECK,
    ST_EXT_WAIT,
    ST_OUT_CHECK,
    ST_OUT_WAIT
  } test_state_t;

  typedef struct packed {
    logic sel_ch_a_n;
    logic sel_ch_b_n;
    logic terminal_select;
    logic speed_zero;
    logic ext_start;
    logic out_start;
  } safety_in_t;

  typedef struct packed {
    logic run_command;
    logic coast_stop_command_n;
    logic quick_stop_command_n;
  } drive_cmd_t;

  typedef struct packed {
    logic main_test_due_alarm;
    logic terminal_test_due_alarm;
    logic extended_test_due_alarm;
    logic output_test_due_alarm;
    logic check_running_note_a;
    logic check_running_note_b;
    logic discrepancy_fault;
    logic test_start_fault;
  } alarm_out_t;

endpackage : torque_off_pkg

//--- tb/safety_controller_model.sv
`timescale 1ns/1ns
module safety_controller_model
  import torque_off_pkg::*;
(
  // Clock
  input wire logic clk,
  // Controller drive
  output safety_in_t safety_in,
  output drive_cmd_t drive_cmd
);
  // The setpoint stays at zero, so every test is requested at standstill.
  initial begin
    safety_in = 6'h34;
    drive_cmd = 3'h3;
  end
  task automatic set_sel(input logic a_n, input logic b_n, input logic term);
    @(posedge clk);
    safety_in.sel_ch_a_n <= a_n;
    safety_in.sel_ch_b_n <= b_n;
    safety_in.terminal_select <= term;
  endtask : set_sel
  task automatic set_start(input logic ext, input logic out);
    @(posedge clk);
    safety_in.ext_start <= ext;
    safety_in.out_start <= out;
  endtask : set_start
  task automatic run_on();
    @(posedge clk);
    drive_cmd.run_command <= 1'h0;
    @(posedge clk);
    drive_cmd.run_command <= 1'h1;
  endtask : run_on
  task automatic set_stop(input logic coast_n, input logic quick_n);
    @(posedge clk);
    drive_cmd.coast_stop_command_n <= coast_n;
    drive_cmd.quick_stop_command_n <= quick_n;
  endtask : set_stop
endmodule : safety_controller_model

//--- tb/torque_off_test_stop_interlock_assertions.sv
`timescale 1ns/1ns
module torque_off_checker
  import torque_off_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched ports
  input wire safety_in_t safety_in,
  input wire drive_cmd_t drive_cmd,
  input wire logic torque_off_active_main,
  input wire logic torque_off_active_extended,
  input wire logic motor_enable,
  input wire logic safety_output,
  input wire logic main_test_request_flag,
  input wire logic extended_test_request_flag,
  input wire alarm_out_t alarms
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_check_end;
    $fell(alarms.check_running_note_a);
  endsequence
  sequence s_start_drop;
    $fell(safety_in.ext_start);
  endsequence
  a_motor_off_sto: assert property (torque_off_active_main |-> !motor_enable)
    else $error("motor enabled under torque-off");
  a_stop_forces_off: assert property (
    (!drive_cmd.coast_stop_command_n || !drive_cmd.quick_stop_command_n) [*2] |-> !motor_enable)
    else $error("motor enabled with stop low");
  a_run_switches_on: assert property ($rose(drive_cmd.run_command) &&
    drive_cmd.coast_stop_command_n && drive_cmd.quick_stop_command_n && !torque_off_active_main
    |=> motor_enable || torque_off_active_main || alarms.check_running_note_a)
    else $error("run edge did not switch on");
  a_run_edge_blocked: assert property ($rose(drive_cmd.run_command) &&
    torque_off_active_main ##1 !torque_off_active_main |-> !motor_enable)
    else $error("run edge taken under torque-off");
  a_notes_paired: assert property (alarms.check_running_note_a == alarms.check_running_note_b)
    else $error("check notes differ");
  a_check_no_torque: assert property (alarms.check_running_note_a |-> !motor_enable)
    else $error("motor enabled during check");
  a_start_fault: assert property ($rose(safety_in.ext_start) && torque_off_active_main
    |-> ##[1:2] alarms.test_start_fault)
    else $error("no fault on start under torque-off");
  a_ext_clears_due: assert property (s_check_end ##[1:200] s_start_drop |-> ##[1:2]
    (!alarms.main_test_due_alarm && !alarms.extended_test_due_alarm) || alarms.test_start_fault)
    else $error("due alarms left after extended test");
  a_disc_forces_sto: assert property (alarms.discrepancy_fault |->
    torque_off_active_main && torque_off_active_extended)
    else $error("discrepancy without torque-off");
  a_flags_follow: assert property (main_test_request_flag == alarms.main_test_due_alarm &&
    extended_test_request_flag == alarms.extended_test_due_alarm)
    else $error("request flags differ from alarms");
  a_output_off_test: assert property ($fell(safety_output) |->
    safety_in.out_start || $past(safety_in.out_start))
    else $error("safety output dropped outside test");
endmodule : torque_off_checker
bind torque_off_test_stop_interlock torque_off_checker u_chk (
  .clk, .rst, .safety_in, .drive_cmd, .torque_off_active_main, .torque_off_active_extended,
  .motor_enable, .safety_output, .main_test_request_flag, .extended_test_request_flag, .alarms
);

//--- tb/tb_torque_off_test_stop_interlock.sv
`timescale 1ns/1ns
module tb_torque_off_test_stop_interlock;
  import torque_off_pkg::*;
  logic clk, rst, wr, rd, irq, motor_enable, safety_output, terminal_select_cause_flag;
  logic torque_off_active_main, torque_off_active_extended;
  logic main_test_request_flag, extended_test_request_flag;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, v, m;
  safety_in_t safety_in;
  drive_cmd_t drive_cmd;
  alarm_out_t alarms;
  int fails, checks_done, low_n, fall_n;
  // Register model: the mode and mask that software last wrote.
  int mdl_mode = 2;
  int mdl_mask = 0;
  integer seed;
  logic p;
  int exp_fall[3] = '{1, 1, 2};
  int lo_min[3] = '{30, 10, 10};
  int lo_max[3] = '{41, 21, 21};
  // A short millisecond tick keeps the interval and check counts small.
  torque_off_test_stop_interlock #(.TICK_CYCLES(10)) uut (
    .clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .safety_in, .drive_cmd,
    .torque_off_active_main, .torque_off_active_extended, .terminal_select_cause_flag,
    .motor_enable, .safety_output, .main_test_request_flag, .extended_test_request_flag,
    .alarms, .irq
  );
  safety_controller_model ctl (.clk, .safety_in, .drive_cmd);
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("mismatch %s expected %0h seen %0h", name, exp, got);
      fails++;
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    if (a == 8'h00) mdl_mode = int'(d[2:0]);
    if (a == 8'h0C) mdl_mask = int'(d[5:0]);
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    v = rdata;
    if (a == 8'h00) chk("mode_model", 32'(mdl_mode), v);
    if (a == 8'h0C) chk("mask_model", 32'(mdl_mask), v);
  endtask : rd_reg
  task automatic final_report();
    if (fails == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    final_report();
  end
  initial begin
    seed = 32'h42D5;
    rst = 1'h1;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'h0;
    rd = 1'h0;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    cyc(1);
    chk("alarms", 8'h00, alarms);
    chk("safety_output", 1'h1, safety_output);
    rd_reg(8'h00);
    chk("ctrl", 32'h2, v);
    rd_reg(8'h40);
    chk("unmapped", 32'h0, v);
    ctl.run_on();
    cyc(2);
    chk("motor_on", 1'h1, motor_enable);
    ctl.set_stop(1'h0, 1'h1);
    cyc(2);
    chk("motor_stop", 1'h0, motor_enable);
    ctl.set_stop(1'h1, 1'h1);
    ctl.run_on();
    for (int i = 0; i < 4; i++) wr_reg(8'h10 + 8'(4 * i), 32'h5);
    m = $random(seed) & 32'h3F;
    wr_reg(8'h0C, m);
    rd_reg(8'h0C);
    cyc(80);
    rd_reg(8'h04);
    chk("due_bits", 4'hF, v[3:0]);
    chk("status", 32'h0000018F, v);
    chk("out_due", 1'h1, alarms.output_test_due_alarm);
    chk("main_flag", 1'h1, main_test_request_flag);
    chk("ext_flag", 1'h1, extended_test_request_flag);
    chk("irq", |m[3:0], irq);
    wr_reg(8'h08, 32'h3F);
    rd_reg(8'h08);
    chk("irq_stat", 32'h0, v);
    ctl.set_sel(1'h0, 1'h0, 1'h0);
    cyc(2);
    chk("sto", 1'h1, torque_off_active_main);
    chk("motor_sto", 1'h0, motor_enable);
    chk("sto_ext", 1'h1, torque_off_active_extended);
    cyc(45);
    ctl.run_on();
    ctl.set_sel(1'h1, 1'h1, 1'h0);
    cyc(3);
    chk("motor_after", 1'h0, motor_enable);
    chk("main_due", 1'h0, alarms.main_test_due_alarm);
    chk("main_flag", 1'h0, main_test_request_flag);
    ctl.run_on();
    ctl.set_sel(1'h1, 1'h1, 1'h1);
    cyc(2);
    chk("cause", 1'h1, terminal_select_cause_flag);
    cyc(45);
    ctl.set_sel(1'h1, 1'h1, 1'h0);
    cyc(3);
    chk("term_due", 1'h0, alarms.terminal_test_due_alarm);
    ctl.run_on();
    ctl.set_start(1'h1, 1'h0);
    cyc(2);
    chk("notes", 2'h3, {alarms.check_running_note_a, alarms.check_running_note_b});
    chk("motor_check", 1'h0, motor_enable);
    cyc(45);
    chk("notes_end", 2'h0, {alarms.check_running_note_a, alarms.check_running_note_b});
    ctl.set_start(1'h0, 1'h0);
    cyc(3);
    chk("due_after_ext", 2'h0, {alarms.main_test_due_alarm, alarms.extended_test_due_alarm});
    chk("ext_flag", 1'h0, extended_test_request_flag);
    ctl.set_sel(1'h0, 1'h0, 1'h0);
    cyc(2);
    ctl.set_start(1'h1, 1'h0);
    cyc(3);
    chk("start_fault", 1'h1, alarms.test_start_fault);
    chk("no_check", 1'h0, alarms.check_running_note_a);
    ctl.set_start(1'h0, 1'h0);
    cyc(45);
    ctl.set_sel(1'h1, 1'h1, 1'h0);
    wr_reg(8'h00, 32'h102);
    cyc(2);
    chk("fault_ack", 1'h0, alarms.test_start_fault);
    for (int k = 0; k < 3; k++) begin
      wr_reg(8'h00, 32'(k + 2));
      rd_reg(8'h00);
      ctl.set_start(1'h0, 1'h1);
      low_n = 0;
      fall_n = 0;
      p = 1'h1;
      repeat (60) begin
        cyc(1);
        low_n += int'(safety_output === 1'h0);
        fall_n += int'(p === 1'h1 && safety_output === 1'h0);
        p = safety_output;
      end
      ctl.set_start(1'h0, 1'h0);
      cyc(3);
      chk("falls", exp_fall[k], fall_n);
      chk("low_time", 1'h1, low_n >= lo_min[k] && low_n <= lo_max[k]);
      chk("out_due", 1'h0, alarms.output_test_due_alarm);
      chk("out_back", 1'h1, safety_output);
    end
    ctl.set_sel(1'h0, 1'h1, 1'h0);
    cyc(120);
    chk("disc", 1'h1, alarms.discrepancy_fault);
    ctl.set_sel(1'h1, 1'h1, 1'h0);
    cyc(2);
    chk("disc_sto", 1'h1, torque_off_active_main);
    rd_reg(8'h08);
    chk("irq_disc", 1'h1, v[4]);
    wr_reg(8'h00, 32'h102);
    cyc(2);
    chk("disc_ack", 2'h0, {alarms.discrepancy_fault, torque_off_active_main});
    final_report();
  end
endmodule : tb_torque_off_test_stop_interlock
